// *** design/pqpc_top.sv ***
// pattern test control: generator routing, error insert, inversion and checker
// Function
// R1 - type bit 0 selects the x^15+x^14+1 sequence, 1 the quasi-random signal
// R2 - switch bit 3 of the switch register picks generating and checking framer
// R3 - switch off: transmit framer sends the pattern toward the line
// R4 - switch on: receive framer sends the pattern toward the receive backplane
// R5 - a 0 to 1 change of the inject bit inverts exactly one output bit
// R6 - the inject bit is ignored unless generation is enabled
// R7 - the injected error appears on the path chosen by the switch
// R8 - invert with switch off: line output and receive checker data inverted
// R9 - invert with switch on: backplane output and transmit checker data inverted
// R10 - invert bit 0: no generated or checked data is inverted
// R11 - generation enable bit turns the generator on, resets to 0
// R12 - one sequence step per bit step of the chosen path, edge found there
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module pqpc_top
  import pqpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  // transmit framer: normal traffic in, line out, backplane pattern in
  input var pqpc_bit_t tx_framer_in,
  input var pqpc_bit_t tx_backplane_in,
  output pqpc_bit_t tx_line_out,
  // receive framer: line in, normal traffic in, backplane out
  input var pqpc_bit_t rx_line_in,
  input var pqpc_bit_t rx_framer_in,
  output pqpc_bit_t rx_backplane_out
);
  logic [DATA_W-1:0] pattern_test_control;
  logic [DATA_W-1:0] switch_control;
  logic [DATA_W-1:0] mismatch_count;
  logic inject_prev;
  logic inject_pending;
  logic gen_bit;
  logic gen_step;
  logic gen_en;
  logic switch_on;
  logic invert;
  logic inject_rise;
  pqpc_kind_t kind;
  logic next_tx_data;
  logic next_rx_data;
  logic check_step;
  logic check_bit;
  logic [LFSR_W-1:0] check_hist;
  logic check_predict;
  logic [4:0] check_fill;

  assign gen_en = pattern_test_control[BIT_GEN_EN];
  assign switch_on = switch_control[BIT_SWITCH];
  assign invert = pattern_test_control[BIT_INVERT];
  assign kind = pattern_test_control[BIT_TYPE] ? PQPC_QRTS : PQPC_PRBS15;

  // ---- register port ----
  always_ff @(posedge clk) begin
    if (rst) begin
      pattern_test_control <= CTRL_RESET; // R11
    end else if (reg_write && reg_addr == ADDR_CTRL) begin
      pattern_test_control <= reg_wdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      switch_control <= SWITCH_RESET;
    end else if (reg_write && reg_addr == ADDR_SWITCH) begin
      switch_control <= reg_wdata; // R2
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ADDR_CTRL: reg_rdata <= pattern_test_control;
        ADDR_SWITCH: reg_rdata <= switch_control;
        ADDR_STATUS: reg_rdata <= mismatch_count;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ---- generator ----
  assign gen_step = gen_en && (switch_on ? rx_framer_in.step : tx_framer_in.step); // R12

  pqpc_pattern_gen u_gen (
    .clk(clk),
    .rst(rst),
    .step(gen_step),
    .kind(kind),
    .pattern_bit(gen_bit)
  );

  // ---- single error insert ----
  always_ff @(posedge clk) begin
    if (rst) begin
      inject_prev <= 1'b0;
    end else begin
      inject_prev <= pattern_test_control[BIT_INJECT];
    end
  end

  assign inject_rise = pattern_test_control[BIT_INJECT] && !inject_prev; // R5

  // a new rise wins over consumption in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      inject_pending <= 1'b0;
    end else if (!gen_en) begin
      inject_pending <= 1'b0; // R6
    end else if (inject_rise) begin
      inject_pending <= 1'b1; // R5
    end else if (gen_step) begin
      inject_pending <= 1'b0; // R5
    end
  end

  // ---- output paths ----
  always_comb begin
    next_tx_data = tx_framer_in.data;
    next_rx_data = rx_framer_in.data;
    if (gen_en && !switch_on) begin
      next_tx_data = gen_bit ^ invert ^ inject_pending; // R3 R7 R8 R10
    end
    if (gen_en && switch_on) begin
      next_rx_data = gen_bit ^ invert ^ inject_pending; // R4 R7 R9 R10
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_line_out <= '0;
    end else begin
      tx_line_out.step <= tx_framer_in.step;
      if (tx_framer_in.step) begin
        tx_line_out.data <= next_tx_data; // R3
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_backplane_out <= '0;
    end else begin
      rx_backplane_out.step <= rx_framer_in.step;
      if (rx_framer_in.step) begin
        rx_backplane_out.data <= next_rx_data; // R4
      end
    end
  end

  // ---- checker: receive framer when switch off, transmit framer when on ----
  always_comb begin
    if (switch_on) begin
      check_step = tx_backplane_in.step;
      check_bit = tx_backplane_in.data ^ invert; // R9 R10
    end else begin
      check_step = rx_line_in.step;
      check_bit = rx_line_in.data ^ invert; // R8 R10
    end
    if (kind == PQPC_PRBS15) begin
      check_predict = check_hist[PRBS_TAP_A] ^ check_hist[PRBS_TAP_B];
    end else begin
      check_predict = check_hist[QRTS_TAP_A] ^ check_hist[QRTS_TAP_B];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      check_hist <= '0;
    end else if (check_step) begin
      check_hist <= {check_hist[LFSR_W-2:0], check_bit};
    end
  end

  // history must be full before predictions count
  always_ff @(posedge clk) begin
    if (rst) begin
      check_fill <= 5'h00;
    end else if (check_step && check_fill != 5'h14) begin
      check_fill <= check_fill + 5'h01;
    end
  end

  // saturating mismatch counter; any write to the status offset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      mismatch_count <= 8'h00;
    end else if (reg_write && reg_addr == ADDR_STATUS) begin
      mismatch_count <= 8'h00;
    end else if (check_step && check_fill == 5'h14 && check_bit != check_predict
                 && mismatch_count != 8'hFF) begin
      mismatch_count <= mismatch_count + 8'h01;
    end
  end

  // ---- assertions ----
  gen_reset_off_a: assert property (@(posedge clk)
    rst |=> !pattern_test_control[BIT_GEN_EN] && !gen_step) // R11
    else $error("generator enabled after reset");

  tx_pattern_out_a: assert property (@(posedge clk) disable iff (rst)
    gen_en && !switch_on && tx_framer_in.step
    |=> tx_line_out.data == $past(gen_bit ^ invert ^ inject_pending)) // R3
    else $error("line output is not the pattern");

  rx_pattern_out_a: assert property (@(posedge clk) disable iff (rst)
    gen_en && switch_on && rx_framer_in.step
    |=> rx_backplane_out.data == $past(gen_bit ^ invert ^ inject_pending)) // R4
    else $error("backplane output is not the pattern");

  tx_passthru_a: assert property (@(posedge clk) disable iff (rst)
    (!gen_en || switch_on) && tx_framer_in.step
    |=> tx_line_out.data == $past(tx_framer_in.data)) // R2
    else $error("line output not normal traffic");

  inject_once_a: assert property (@(posedge clk) disable iff (rst)
    inject_pending && gen_step && !inject_rise |=> !inject_pending) // R5
    else $error("error insert not consumed after one bit");

  inject_arm_a: assert property (@(posedge clk) disable iff (rst)
    gen_en && inject_rise ##1 gen_en |-> inject_pending) // R5
    else $error("rising inject bit did not arm an error");

  inject_hold_a: assert property (@(posedge clk) disable iff (rst)
    $stable(pattern_test_control) && inject_prev && !inject_pending
    |=> !inject_pending) // R5
    else $error("inject bit held high caused another error");

  inject_gate_a: assert property (@(posedge clk) disable iff (rst)
    !gen_en |=> !inject_pending) // R6
    else $error("error armed while generation disabled");

  tx_error_bit_a: assert property (@(posedge clk) disable iff (rst)
    gen_en && !switch_on && inject_pending && tx_framer_in.step
    |=> tx_line_out.data != $past(gen_bit ^ invert)) // R7
    else $error("injected error missing on line output");

  rx_error_bit_a: assert property (@(posedge clk) disable iff (rst)
    gen_en && switch_on && inject_pending && rx_framer_in.step
    |=> rx_backplane_out.data != $past(gen_bit ^ invert)) // R7
    else $error("injected error missing on backplane output");

  rx_check_inv_a: assert property (@(posedge clk) disable iff (rst)
    !switch_on && rx_line_in.step
    |=> check_hist[0] == $past(rx_line_in.data ^ invert)) // R8
    else $error("receive checker inversion wrong");

  tx_check_inv_a: assert property (@(posedge clk) disable iff (rst)
    switch_on && tx_backplane_in.step
    |=> check_hist[0] == $past(tx_backplane_in.data ^ invert)) // R9
    else $error("transmit checker inversion wrong");

  no_invert_a: assert property (@(posedge clk) disable iff (rst)
    !invert && !inject_pending && gen_en && !switch_on && tx_framer_in.step
    |=> tx_line_out.data == $past(gen_bit)) // R10
    else $error("pattern inverted with invert bit clear");

  step_follow_a: assert property (@(posedge clk) disable iff (rst)
    gen_en && !switch_on |-> gen_step == tx_framer_in.step) // R12
    else $error("generator not stepping with line bit clock");
endmodule : pqpc_top
`default_nettype wire

// *** design/pqpc_pkg.sv ***
// package: register map, field positions and stream carrier for pattern test control
package pqpc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // register offsets
  localparam logic [7:0] ADDR_SWITCH = 8'h21;
  localparam logic [7:0] ADDR_CTRL = 8'h23;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  // pattern_test_control fields
  localparam int BIT_TYPE = 7;
  localparam int BIT_INJECT = 6;
  localparam int BIT_INVERT = 5;
  localparam int BIT_LOCK = 4;
  localparam int BIT_GEN_EN = 2;
  // switch register field
  localparam int BIT_SWITCH = 3;
  // reset values and control write mask
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] SWITCH_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'hEF;
  // generator lengths
  localparam int LFSR_W = 20;
  localparam int PRBS_TAP_A = 14;
  localparam int PRBS_TAP_B = 13;
  localparam int QRTS_TAP_A = 19;
  localparam int QRTS_TAP_B = 16;
  localparam logic [3:0] QRTS_ZERO_LIMIT = 4'hE;
  localparam logic [LFSR_W-1:0] LFSR_SEED = 20'h00001;

  typedef enum logic {PQPC_PRBS15, PQPC_QRTS} pqpc_kind_t;

  // one serial bit with its bit-step strobe
  typedef struct packed {
    logic step;
    logic data;
  } pqpc_bit_t;
endpackage : pqpc_pkg

// *** design/pqpc_pattern_gen.sv ***
// pseudo-random and quasi-random test sequence generator
`timescale 1ns/1ns
`default_nettype none
module pqpc_pattern_gen
  import pqpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic step,
  input var pqpc_kind_t kind,
  // sequence bit for the current step
  output logic pattern_bit
);
  logic [LFSR_W-1:0] lfsr;
  logic [3:0] zero_run;
  logic feedback;
  logic raw_bit;

  always_comb begin
    if (kind == PQPC_PRBS15) begin
      feedback = lfsr[PRBS_TAP_A] ^ lfsr[PRBS_TAP_B]; // R1
      raw_bit = feedback;
    end else begin
      feedback = lfsr[QRTS_TAP_A] ^ lfsr[QRTS_TAP_B]; // R1
      raw_bit = lfsr[QRTS_TAP_A];
    end
    // quasi-random signal never emits more than fourteen zeros in a row
    pattern_bit = raw_bit | (kind == PQPC_QRTS && zero_run == QRTS_ZERO_LIMIT);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr <= LFSR_SEED;
    end else if (step) begin
      lfsr <= {lfsr[LFSR_W-2:0], feedback}; // R12
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      zero_run <= 4'h0;
    end else if (step) begin
      zero_run <= pattern_bit ? 4'h0 : zero_run + 4'h1;
    end
  end

  prbs_shift_a: assert property (@(posedge clk) disable iff (rst)
    step && kind == PQPC_PRBS15 |=> lfsr[0] == $past(pattern_bit)) // R1
    else $error("prbs feedback not shifted in");
endmodule : pqpc_pattern_gen
`default_nettype wire

// *** bench/pqpc_far_end.sv ***
// far-end model: framer bit steps, normal traffic, line and backplane loopback
`timescale 1ns/1ns
`default_nettype none
module pqpc_far_end
  import pqpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cycles between bit steps, 1 gives back-to-back steps
  input wire logic [3:0] gap,
  // from the block
  input var pqpc_bit_t tx_line_out,
  input var pqpc_bit_t rx_backplane_out,
  // to the block
  output var pqpc_bit_t tx_framer_in,
  output var pqpc_bit_t rx_framer_in,
  output var pqpc_bit_t rx_line_in,
  output var pqpc_bit_t tx_backplane_in
);
  logic [3:0] cnt;

  // normal traffic toggles on every step so pass-through is visible
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 4'h0;
      tx_framer_in <= '0;
      rx_framer_in <= '0;
    end else begin
      cnt <= (cnt + 4'h1 >= gap) ? 4'h0 : cnt + 4'h1;
      tx_framer_in.step <= (cnt == 4'h0);
      rx_framer_in.step <= (cnt == 4'h0);
      if (cnt == 4'h0) begin
        tx_framer_in.data <= ~tx_framer_in.data;
        rx_framer_in.data <= ~rx_framer_in.data;
      end
    end
  end

  // line and backplane hand back what the block sent, one cycle later
  always_ff @(posedge clk) begin
    rx_line_in <= rst ? '0 : tx_line_out;
    tx_backplane_in <= rst ? '0 : rx_backplane_out;
  end
endmodule : pqpc_far_end
`default_nettype wire

// *** bench/pqpc_top_bench.sv ***
// self-checking testbench for pattern test control
`timescale 1ns/1ns
`default_nettype none
module pqpc_top_bench;
  import pqpc_pkg::*;
  logic clk, rst, reg_write, reg_read;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] gap;
  pqpc_bit_t tx_framer_in, tx_backplane_in, tx_line_out;
  pqpc_bit_t rx_line_in, rx_framer_in, rx_backplane_out;
  int bad_count, compares;
  logic bits[$];

  pqpc_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tx_framer_in(tx_framer_in), .tx_backplane_in(tx_backplane_in),
    .tx_line_out(tx_line_out), .rx_line_in(rx_line_in), .rx_framer_in(rx_framer_in),
    .rx_backplane_out(rx_backplane_out));
  pqpc_far_end far (.clk(clk), .rst(rst), .gap(gap), .tx_line_out(tx_line_out),
    .rx_backplane_out(rx_backplane_out), .tx_framer_in(tx_framer_in),
    .rx_framer_in(rx_framer_in), .rx_line_in(rx_line_in),
    .tx_backplane_in(tx_backplane_in));

  always #20 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    // one idle edge so a following write never reassigns the strobe in this step
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    @(posedge clk);
  endtask : rd

  // gathers n stepped bits from the line output or the backplane output
  task automatic grab(input int n, input bit rxs);
    int guard;
    bits = {};
    guard = 0;
    while (bits.size() < n && guard < 2000) begin
      @(negedge clk);
      guard++;
      if (rxs ? rx_backplane_out.step : tx_line_out.step)
        bits.push_back(rxs ? rx_backplane_out.data : tx_line_out.data);
    end
    @(posedge clk);
    check(8'(bits.size()), 8'(n));
  endtask : grab

  // breaks of the x^15+x^14+1 recurrence; an inverted stream breaks it everywhere
  function automatic logic [7:0] viol(input logic inv);
    logic [7:0] c;
    c = 8'h00;
    for (int n = 20; n < bits.size(); n++)
      if ((bits[n] ^ bits[n-14] ^ bits[n-15]) !== inv) c++;
    return c;
  endfunction : viol

  function automatic logic [7:0] same();
    logic [7:0] c;
    c = 8'h00;
    for (int n = 2; n < bits.size(); n++)
      if (bits[n] === bits[n-1]) c++;
    return c;
  endfunction : same

  // one flipped bit breaks the recurrence at three places inside the window
  task automatic run_gen(input logic [7:0] c, input bit rxs, input bit inj);
    wr(ADDR_CTRL, c & 8'hBF);
    fork
      grab(70, rxs);
      begin
        repeat (30 * gap) @(posedge clk);
        if (inj) wr(ADDR_CTRL, c);
      end
    join
  endtask : run_gen

  task automatic t_regs;
    logic [7:0] d;
    rd(ADDR_CTRL, d);
    check(d, CTRL_RESET);
    rd(ADDR_SWITCH, d);
    check(d, SWITCH_RESET);
    wr(ADDR_CTRL, 8'hFF);
    rd(ADDR_CTRL, d);
    check(d, 8'hEF);
    wr(ADDR_SWITCH, 8'hA5);
    rd(ADDR_SWITCH, d);
    check(d, 8'hA5);
    wr(ADDR_SWITCH, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    wr(8'h7F, 8'hFF);
    rd(8'h7F, d);
    check(d, 8'h00);
    $display("register test done");
  endtask : t_regs

  task automatic t_tx_pattern;
    logic [7:0] d;
    run_gen(8'h04, 0, 0);
    check(viol(0), 8'h00);
    run_gen(8'h24, 0, 0);
    check(viol(1), 8'h00);
    wr(ADDR_STATUS, 8'h00);
    grab(40, 0);
    rd(ADDR_STATUS, d);
    check(d, 8'h00);
    run_gen(8'h44, 0, 1);
    check(viol(0), 8'h03);
    rd(ADDR_STATUS, d);
    check(8'(d != 8'h00), 8'h01);
    grab(70, 0);
    check(viol(0), 8'h00);
    $display("transmit pattern test done");
  endtask : t_tx_pattern

  task automatic t_gate;
    // drop the inject bit first so its rise falls while generation is off
    wr(ADDR_CTRL, 8'h00);
    wr(ADDR_CTRL, 8'h40);
    grab(20, 0);
    check(same(), 8'h00);
    wr(ADDR_CTRL, 8'h44);
    grab(70, 0);
    check(viol(0), 8'h00);
    run_gen(8'h84, 0, 0);
    check(8'(viol(0) == 8'h00), 8'h00);
    $display("gating and type test done");
  endtask : t_gate

  task automatic t_switch;
    logic [7:0] d;
    gap <= 4'h3;
    wr(ADDR_SWITCH, 8'h08);
    run_gen(8'h64, 1, 1);
    check(viol(1), 8'h03);
    grab(20, 0);
    check(same(), 8'h00);
    wr(ADDR_STATUS, 8'h00);
    grab(40, 1);
    check(viol(1), 8'h00);
    rd(ADDR_STATUS, d);
    check(d, 8'h00);
    gap <= 4'h1;
    wr(ADDR_SWITCH, 8'h00);
    $display("switched path test done");
  endtask : t_switch

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  initial begin
    #800000;
    bad_count++;
    print_verdict();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    gap = 4'h1;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_tx_pattern();
    t_gate();
    t_switch();
    print_verdict();
  end
endmodule : pqpc_top_bench
`default_nettype wire
